// [bench/sdr_chk_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module sdr_chk #(parameter int CUR_W = 10, parameter int FAULT_W = 8)(
  input wire logic mclk, sys_rst, supply_ok, supply_valid, safe_in,
  input wire logic safe_in_oe, cmd_valid, cmd_ch, ch_en_r, so_oe_r,
  input wire logic diag_ok_r,
  input wire logic [CUR_W-1:0] cmd_cur, cur0_r, cur1_r,
  input wire logic [FAULT_W-1:0] fault_r,
  input wire logic [1:0] slew0_r
);
  // Open pin counts as safe; commands legal 7 edges after reset
  logic [2:0] up_r;
  wire sl = !safe_in_oe || safe_in;
  wire rdy = up_r == 3'h7 && !sl;
  wire bad = sys_rst || !supply_ok;
  always_ff @(posedge mclk) up_r <= bad ? 3'h0 : up_r + 3'(up_r != 3'h7);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Reset is registered once inside the stretcher, so clearing lands 2 edges on
  property p_por; !supply_ok |-> ##2 cur0_r == '0 && cur1_r == '0 && !ch_en_r
    && fault_r == '0 && slew0_r == 2'h0; endproperty
  a_por: assert property (p_por) else $error("por");
  property p_safe; sl |=> cur0_r == '0 && cur1_r == '0 && !ch_en_r; endproperty
  a_safe: assert property (p_safe) else $error("safe");
  property p_so; sl |=> !so_oe_r; endproperty
  a_so: assert property (p_so) else $error("so");
  property p_flt; sl && supply_ok && up_r == 3'h7 |=>
    (fault_r & $past(fault_r)) == $past(fault_r); endproperty
  a_flt: assert property (p_flt) else $error("flt");
  property p_cmd; rdy && cmd_valid && !cmd_ch |=>
    cur0_r == $past(cmd_cur) && ch_en_r; endproperty
  a_cmd: assert property (p_cmd) else $error("cmd");
  property p_one; rdy && cmd_valid && cmd_ch |=>
    cur1_r == $past(cmd_cur) && cur0_r == $past(cur0_r); endproperty
  a_one: assert property (p_one) else $error("one");
  property p_rel; $fell(sl) && !cmd_valid |=> cur0_r == '0 && !ch_en_r;
  endproperty
  a_rel: assert property (p_rel) else $error("rel");
  property p_diag; !supply_valid |=> !diag_ok_r; endproperty
  a_diag: assert property (p_diag) else $error("diag");
endmodule
bind sdr_safe_ctrl sdr_chk #(.CUR_W(CUR_W), .FAULT_W(FAULT_W)) sdr_chk_inst (.*);
`default_nettype wire

// [bench/sdr_host.sv]
`timescale 1ns/100ps
`default_nettype none
module sdr_host (
  input  wire logic supply_valid, safe_req, pin_open,
  output logic      safe_in, safe_in_oe, test_in, test_in_oe
);
  // Open pin floats up through the weak pull-up
  assign safe_in = pin_open || safe_req || !supply_valid;
  assign safe_in_oe = !pin_open;
  assign test_in = 1'b0;
  assign test_in_oe = 1'b1;
endmodule
`default_nettype wire

// [bench/solenoid_driver_reset_safe_state_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none
module solenoid_driver_reset_safe_state_tb_top;
  logic mclk = 0, sys_rst = 1, supply_ok = 1, supply_valid = 1, safe_req = 0;
  logic pin_open = 0, cmd_valid = 0, cmd_ch = 0, diag_in = 1, so_data = 0;
  logic so_active = 1, safe_in, safe_in_oe, test_in, test_in_oe, ch_en_r;
  logic so_oe_r, diag_ok_r, test_mode_r, so_out_r, safe_r;
  logic [9:0] cmd_cur = '0, cur0_r, cur1_r, r;
  logic [7:0] fault_set = '0, fault_r;
  logic [1:0] cmd_slew = '0, slew0_r, slew1_r;
  sdr_pkg::sdr_state_t state_r;
  logic [19:0] q[$];
  int bad_count = 0, n_compared = 0;
  always #2 mclk = ~mclk;
  sdr_host sdr_host_inst (.*);
  sdr_safe_ctrl sdr_safe_ctrl_inst (.*);
  task automatic check(input logic [19:0] seen, exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic send(input logic ch, input logic [9:0] v, input logic [19:0] e);
    @(posedge mclk);
    cmd_valid <= 1;
    cmd_ch <= ch;
    cmd_cur <= v;
    cmd_slew <= v[1:0];
    q.push_back(e);
    @(posedge mclk);
    cmd_valid <= 0;
  endtask
  always @(posedge mclk) if (cmd_valid)
  begin
    #1 check({cur1_r, cur0_r}, q.pop_front());
  end
  initial
  begin
    #100000 bad_count++;
    wrap_up;
  end
  initial
  begin
    void'($urandom(92));
    repeat (20) @(posedge mclk);
    sys_rst <= 0;
    repeat (8) @(posedge mclk);
    r = 10'($urandom);
    so_data <= r[2];
    send(0, r, {10'h000, r});
    send(1, ~r, {~r, r});
    #1 check({slew1_r, slew0_r, test_mode_r, safe_r, state_r, so_oe_r, so_out_r},
      {~r[1:0], r[1:0], 2'b00, sdr_pkg::SDR_ST_RUN, 1'b1, r[2]});
    $display("command test done");
    fault_set <= 8'h5A;
    @(posedge mclk) fault_set <= 8'h00;
    safe_req <= 1;
    send(0, ~r, 20'h0);
    #1 check({so_oe_r, fault_r}, 20'h0005A);
    check({safe_r, state_r, slew0_r}, {1'b1, sdr_pkg::SDR_ST_SAFE, 2'b00});
    safe_req <= 0;
    repeat (2) @(posedge mclk);
    send(1, r, {r, 10'h000});
    pin_open <= 1;
    send(1, ~r, 20'h0);
    pin_open <= 0;
    $display("safe test done");
    // Load a live current so the supply reset has something to clear
    send(0, r, {10'h000, r});
    supply_ok <= 0;
    repeat (3) @(posedge mclk);
    #1 check({cur1_r | cur0_r, fault_r}, 20'h0);
    supply_ok <= 1;
    repeat (8) @(posedge mclk);
    send(0, r, {10'h000, r});
    supply_valid <= 0;
    repeat (2) @(posedge mclk);
    #1 check({diag_ok_r, cur0_r}, 20'h0);
    $display("supply test done");
    wrap_up;
  end
endmodule
`default_nettype wire

// [core/sdr_params.svh]
`ifndef SDR_PARAMS_SVH
`define SDR_PARAMS_SVH
// ======================================================
// Defaults and timing
`define SDR_CUR_DEFAULT   10'h000
`define SDR_SLEW_DEFAULT  2'h0
`define SDR_FAULT_CLEAR   8'h00
`define SDR_RST_HOLD_NS   16
`define SDR_MCLK_MHZ      250
`define SDR_RST_HOLD_CYC  ((`SDR_RST_HOLD_NS * `SDR_MCLK_MHZ + 999) / 1000)
`endif

// [core/sdr_pkg.sv]
package sdr_pkg;
  typedef enum logic [1:0]
  {
    SDR_ST_RESET = 2'b00,
    SDR_ST_OFF   = 2'b01,
    SDR_ST_RUN   = 2'b10,
    SDR_ST_SAFE  = 2'b11
  } sdr_state_t;
endpackage

// [core/sdr_rst_hold.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sdr_params.svh"
// ======================================================
// Reset stretcher: holds while supply bad, then a few cycles
module sdr_rst_hold #(
  parameter int HOLD = `SDR_RST_HOLD_CYC
)(
  input  wire logic mclk,       // Clock
  input  wire logic sys_rst,    // Sync reset
  input  wire logic supply_ok,  // Logic supply above reset point
  output logic      rst_out     // Stretched internal reset
);
  localparam int CW = $clog2(HOLD + 1);
  initial
  begin
    if (HOLD < 1)
      $error("HOLD must be at least 1");
  end
  logic [CW-1:0] cnt_r;
  wire           busy = (cnt_r != '0);
  always_ff @(posedge mclk)
  begin
    if (sys_rst || !supply_ok)
    begin
      cnt_r   <= CW'(HOLD);
      rst_out <= 1'b1;
    end
    else
    begin
      cnt_r   <= busy ? cnt_r - 1'b1 : cnt_r;
      rst_out <= busy;
    end
  end
endmodule
`default_nettype wire

// [core/sdr_safe_ctrl.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sdr_params.svh"
// ======================================================
// Reset and safe-state control, two channels
module sdr_safe_ctrl #(
  parameter int CUR_W   = 10,
  parameter int FAULT_W = 8
)(
  input  wire logic               mclk,          // Clock
  input  wire logic               sys_rst,       // Sync reset
  input  wire logic               supply_ok,     // Supply above POR
  input  wire logic               supply_valid,  // Supply at 4.75 V+
  input  wire logic               safe_in,       // Safe-state pin level
  input  wire logic               safe_in_oe,    // Pin driven externally
  input  wire logic               test_in,       // Factory test pin
  input  wire logic               test_in_oe,    // Test pin driven
  input  wire logic               cmd_valid,     // Decoded command strobe
  input  wire logic               cmd_ch,        // Target channel
  input  wire logic [CUR_W-1:0]   cmd_cur,       // Commanded current
  input  wire logic [1:0]         cmd_slew,      // Slew setting
  input  wire logic [FAULT_W-1:0] fault_set,     // Fault events
  input  wire logic               diag_in,       // Raw diagnostic flag
  input  wire logic               so_data,       // Serial out data
  input  wire logic               so_active,     // Frame wants SO
  output logic [CUR_W-1:0]        cur0_r,        // Channel 0 current
  output logic [CUR_W-1:0]        cur1_r,        // Channel 1 current
  output logic [1:0]              slew0_r,       // Channel 0 slew
  output logic [1:0]              slew1_r,       // Channel 1 slew
  output logic                    ch_en_r,       // Channels enabled
  output logic [FAULT_W-1:0]      fault_r,       // Fault bits
  output logic                    diag_ok_r,     // Diagnostic valid
  output logic                    test_mode_r,   // Test mode flag
  output logic                    so_out_r,      // SO data
  output logic                    so_oe_r,       // SO output enable
  output logic                    safe_r,        // Safe state active
  output sdr_pkg::sdr_state_t     state_r        // Control state
);
  initial
  begin
    if (CUR_W < 1 || FAULT_W < 1)
      $error("Widths must be positive");
  end
  logic rst_int;
  sdr_rst_hold u_hold (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .supply_ok (supply_ok),
    .rst_out   (rst_int)
  );
  // ======================================================
  // Pin decode
  wire safe_lvl = safe_in_oe ? safe_in : 1'b1;
  wire test_lvl = test_in_oe ? test_in : 1'b0;
  wire take_cmd = cmd_valid && !safe_lvl;
  wire to_defaults = rst_int || safe_lvl;
  wire wr0 = take_cmd && !cmd_ch;
  wire wr1 = take_cmd && cmd_ch;
  sdr_pkg::sdr_state_t state_nxt;
  always_comb
  begin
    case (state_r)
      sdr_pkg::SDR_ST_RESET: state_nxt = sdr_pkg::SDR_ST_OFF;
      sdr_pkg::SDR_ST_OFF:   state_nxt = take_cmd ? sdr_pkg::SDR_ST_RUN
                                                  : sdr_pkg::SDR_ST_OFF;
      sdr_pkg::SDR_ST_RUN:   state_nxt = sdr_pkg::SDR_ST_RUN;
      sdr_pkg::SDR_ST_SAFE:  state_nxt = sdr_pkg::SDR_ST_OFF;
      default:               state_nxt = sdr_pkg::SDR_ST_RESET;
    endcase
    if (safe_lvl)
      state_nxt = sdr_pkg::SDR_ST_SAFE;
  end
  // ======================================================
  // State and registers
  always_ff @(posedge mclk)
  begin
    if (rst_int)
      state_r <= sdr_pkg::SDR_ST_RESET;
    else
      state_r <= state_nxt;
  end
  always_ff @(posedge mclk)
  begin
    if (to_defaults)
    begin
      cur0_r  <= CUR_W'(`SDR_CUR_DEFAULT);
      cur1_r  <= CUR_W'(`SDR_CUR_DEFAULT);
      slew0_r <= `SDR_SLEW_DEFAULT;
      slew1_r <= `SDR_SLEW_DEFAULT;
      ch_en_r <= 1'b0;
    end
    else
    begin
      if (wr0)
      begin
        cur0_r  <= cmd_cur;
        slew0_r <= cmd_slew;
      end
      if (wr1)
      begin
        cur1_r  <= cmd_cur;
        slew1_r <= cmd_slew;
      end
      ch_en_r <= ch_en_r | take_cmd;
    end
  end
  // Safe state leaves faults alone; only reset wipes them
  always_ff @(posedge mclk)
  begin
    if (rst_int)
      fault_r <= FAULT_W'(`SDR_FAULT_CLEAR);
    else
      fault_r <= fault_r | fault_set;
  end
  always_ff @(posedge mclk)
  begin
    if (rst_int)
    begin
      diag_ok_r   <= 1'b0;
      test_mode_r <= 1'b0;
      so_out_r    <= 1'b0;
      so_oe_r     <= 1'b0;
      safe_r      <= 1'b1;
    end
    else
    begin
      diag_ok_r   <= supply_valid && diag_in;
      test_mode_r <= test_lvl;
      so_out_r    <= so_data;
      so_oe_r     <= so_active && !safe_lvl;
      safe_r      <= safe_lvl;
    end
  end
endmodule
`default_nettype wire
